/* bench/ompd_wake_model.sv */
// wake event sources and software reprogram tracker for the mode controller
`timescale 1ns/1ns
`default_nettype none
module ompd_wake_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // command from the bench: source mask and delay, go is a pulse
    input wire logic go,
    input wire logic [4:0] want,
    input wire logic [3:0] dly,
    // device state seen by software
    input wire logic cpu_run,
    input wire logic reconfig_needed,
    // wake lines: periph irq, low-power irq, reset pin, debug, io match
    output logic [4:0] src,
    // number of full reprogram passes done by software
    output logic [7:0] reprog_cnt
);
    logic [4:0] pend_q;
    logic [4:0] cnt_q;

    // a source stays high until software services it in run mode or go arrives with an empty mask
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src <= 5'h00;
            pend_q <= 5'h00;
            cnt_q <= 5'h1F;
        end else if (go) begin
            pend_q <= want;
            cnt_q <= {1'b0, dly};
            if (want == 5'h00) begin
                src <= 5'h00;
            end
        end else if (cnt_q != 5'h1F) begin
            if (cnt_q == 5'h00) begin
                src <= pend_q;
            end
            cnt_q <= cnt_q - 5'h01;
        end else if (cpu_run) begin
            src <= 5'h00;
        end
    end

    // software reloads every register after losing power
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reprog_cnt <= 8'h00;
        end else if (reconfig_needed) begin
            reprog_cnt <= reprog_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* bench/operating_mode_power_domain_ctrl_test.sv */
// self-checking bench of the operating mode and power domain controller
`timescale 1ns/1ns
`default_nettype none
module operating_mode_power_domain_ctrl_test;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    ompd_pkg::ompd_mode_e req_mode = ompd_pkg::OMPD_RUN;
    logic [1:0] req_level = 2'h0;
    logic cpu_enter = 1'b0;
    logic go = 1'b0;
    logic [4:0] want = 5'h00;
    logic [3:0] dly = 4'h0;
    logic [15:0] func_avail = 16'h0000;
    logic [7:0] func_sw_enable = 8'h00;
    logic [4:0] src;
    logic [7:0] reprog_cnt;
    ompd_pkg::ompd_mode_e mode;
    logic [1:0] level, lpclk;
    logic cpu_run, reg_on, hpd, lpd, osc, tmr, fastreq, reconfig;
    logic [7:0] fclk, fpwr;
    int miscompares = 0;
    int cmp_count = 0;
    int seed = 32'haa26;

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    ompd_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n),
        .req_mode(req_mode), .req_level(req_level), .cpu_enter(cpu_enter),
        .periph_irq(src[0]), .low_power_irq(src[1]),
        .external_reset_pin(src[2]), .debug_active(src[3]),
        .io_wake_match(src[4]), .func_avail(func_avail),
        .func_sw_enable(func_sw_enable), .mode(mode), .level(level),
        .cpu_run(cpu_run), .regulator_on(reg_on), .high_perf_domain(hpd),
        .low_power_domain(lpd), .system_oscillator(osc),
        .low_power_periph_clock(lpclk), .lp_timer_clk_en(tmr),
        .periph_fast_req_en(fastreq), .func_clk_en(fclk),
        .func_pwr_en(fpwr), .reconfig_needed(reconfig));

    ompd_wake_model wake_src (.core_clk(core_clk), .rst_n(rst_n), .go(go),
        .want(want), .dly(dly), .cpu_run(cpu_run),
        .reconfig_needed(reconfig), .src(src), .reprog_cnt(reprog_cnt));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic close_out;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // requested level clipped to the mode's highest level
    function automatic logic [1:0] clip(input logic [2:0] m,
                                        input logic [1:0] l);
        logic [1:0] mx;
        mx = (m == 3'h3) ? ompd_pkg::STANDBY_LEVEL_MAX
            : ompd_pkg::RUN_LEVEL_MAX;
        return (l > mx) ? mx : l;
    endfunction

    // enabled runs, disabled stops, optional and unsupported follow software
    function automatic logic [7:0] exp_clk(input logic [15:0] av,
                                           input logic [7:0] sw);
        for (int i = 0; i < 8; i++) begin
            exp_clk[i] = (av[2*i+:2] == ompd_pkg::AVAIL_EN)
                | ((av[2*i+:2] != ompd_pkg::AVAIL_DIS) & sw[i]);
        end
    endfunction

    task automatic enter(input logic [2:0] m, input logic [1:0] l);
        @(posedge core_clk);
        req_mode <= ompd_pkg::ompd_mode_e'(m);
        req_level <= l;
        cpu_enter <= 1'b1;
        @(posedge core_clk);
        cpu_enter <= 1'b0;
        #1;
    endtask

    // tell the wake model to raise sources, optionally wait for run
    task automatic wake(input logic [4:0] w, input logic [3:0] d,
                        input bit wait_run);
        int n;
        @(posedge core_clk);
        go <= 1'b1;
        want <= w;
        dly <= d;
        @(posedge core_clk);
        go <= 1'b0;
        n = 0;
        while (wait_run && cpu_run !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 40) begin
            miscompares++;
            close_out();
        end
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [2:0] m;
        logic [1:0] rl, l;
        logic [7:0] rc;
        @(posedge core_clk);
        #1;
        chk({mode, level}, {3'h0, ompd_pkg::OMPD_RUN,
            ompd_pkg::RESET_LEVEL});
        chk({osc, lpclk, reconfig}, {4'h0, 1'b1,
            ompd_pkg::LPCLK_FAST, 1'b0});
        chk({reg_on, hpd, lpd}, 8'h07);
        @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            rl = 2'($random(seed));
            m = 3'h1 + 3'($random(seed) & 3);
            l = 2'($random(seed));
            if (i < 12) begin
                m = 3'h1 + 3'(i % 4);
                rl = 2'(i / 4);
                l = (m == 3'h3) ? 2'h1 : 2'h0;
            end
            enter(3'h0, rl);
            chk(level, clip(3'h0, rl));
            chk({cpu_run, reg_on, hpd, lpd}, 8'h0F);
            @(posedge core_clk);
            func_avail <= 16'($random(seed));
            func_sw_enable <= 8'($random(seed));
            #1;
            chk(fclk, exp_clk(func_avail, func_sw_enable));
            chk(fpwr, 8'hFF);
            enter(m, l);
            chk(mode, m);
            chk(cpu_run, 8'h00);
            chk({reg_on, hpd, lpd}, (m == 3'h1) ? 8'h07 :
                (m == 3'h4) ? 8'h00 : 8'h05);
            if (m != 3'h4) chk(level, clip(m, l));
            if (m == 3'h2 && l == 2'h0) begin
                chk(osc, clip(3'h0, rl) != 2'h2);
                chk(lpclk, (clip(3'h0, rl) == 2'h0) ? 8'h02 : 8'h01);
            end
            if (m == 3'h2 && l == 2'h1) chk(lpclk, 8'h02);
            if (m == 3'h3 && l != 2'h0)
                chk({lpclk, tmr, fastreq}, 8'h03);
            if (m == 3'h3 && l == 2'h0) chk(lpclk, 8'h01);
            if (m == 3'h4) chk(fclk, 8'h00);
            if (m == 3'h4) chk(fpwr, 8'h00);
            enter(3'h0, 2'h0);
            chk(mode, m);
            if (m == 3'h2 && l == 2'h0) chk({osc, lpclk},
                {5'h00, clip(3'h0, rl) != 2'h2,
                (clip(3'h0, rl) == 2'h0) ? ompd_pkg::LPCLK_4M
                : ompd_pkg::LPCLK_32K});
            if (m == 3'h1 || m == 3'h4) begin
                wake((m == 3'h4) ? 5'h03 : 5'h02, 4'h0, 1'b0);
                repeat (4) @(posedge core_clk);
                #1;
                chk(mode, m);
                wake(5'h00, 4'h0, 1'b0);
            end
            rc = reprog_cnt;
            wake((m == 3'h4) ? (5'h04 << (i % 3)) :
                 (m == 3'h1 || i[0]) ? 5'h01 : 5'h02,
                 4'($random(seed)), 1'b1);
            chk(mode, 8'h00);
            if (m != 3'h4) chk(level, clip(3'h0, rl));
            repeat (3) @(posedge core_clk);
            #1;
            chk(reprog_cnt, rc + ((m == 3'h4) ? 8'h01 : 8'h00));
        end
        close_out();
    end
endmodule
`default_nettype wire

/* core/ompd_ctrl.sv */
// operating mode sequencer and power domain control
`timescale 1ns/1ns
`default_nettype none
// How it works
// - five modes run to shutdown; cpu runs only in run mode
// - peripheral interrupt returns sleep, stop or standby to run
// - shutdown turns regulator off; wakes only by reset pin, debug, io match
// - high-performance domain on in run and sleep, off otherwise
// - low-power domain on except shutdown
// - run, sleep, stop, standby each have selectable policy levels
// - disabled functions are clock gated but keep configuration
// - optional functions keep running when software enabled them
// - unsupported functions are not turned off on mode entry
// - powered-off functions lose state; software reprograms after wake
// - stop level zero from run level one keeps oscillator and 32 kHz
// - standby level one clocks only low-power timers and rtc
module ompd_ctrl (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // mode request from the processor
    input wire ompd_pkg::ompd_mode_e req_mode,
    input wire logic [1:0] req_level,
    input wire logic cpu_enter,
    // wake sources
    input wire logic periph_irq,
    input wire logic low_power_irq,
    input wire logic external_reset_pin,
    input wire logic debug_active,
    input wire logic io_wake_match,
    // per-function classes for the current mode and software enables
    input wire logic [15:0] func_avail,
    input wire logic [7:0] func_sw_enable,
    // state
    output ompd_pkg::ompd_mode_e mode,
    output logic [1:0] level,
    output logic cpu_run,
    output logic regulator_on,
    output logic high_perf_domain,
    output logic low_power_domain,
    output logic system_oscillator,
    output logic [1:0] low_power_periph_clock,
    output logic lp_timer_clk_en,
    output logic periph_fast_req_en,
    // per-function gates and a pulse to tell software to reprogram
    output logic [7:0] func_clk_en,
    output logic [7:0] func_pwr_en,
    output logic reconfig_needed
);
    ompd_pkg::ompd_mode_e mode_q, mode_d;
    logic [1:0] level_q, level_d;
    logic [1:0] run_level_q, run_level_d;
    logic osc_q, osc_d;
    logic [1:0] lpclk_q, lpclk_d;
    logic reconf_q, reconf_d;
    logic [1:0] req_cap;
    logic wake;
    logic off_any;

    // clip the requested level to the mode's range
    always_comb begin
        req_cap = req_level;
        case (req_mode)
            ompd_pkg::OMPD_RUN:
                if (req_level > ompd_pkg::RUN_LEVEL_MAX)
                    req_cap = ompd_pkg::RUN_LEVEL_MAX;
            ompd_pkg::OMPD_SLEEP:
                if (req_level > ompd_pkg::SLEEP_LEVEL_MAX)
                    req_cap = ompd_pkg::SLEEP_LEVEL_MAX;
            ompd_pkg::OMPD_STOP:
                if (req_level > ompd_pkg::STOP_LEVEL_MAX)
                    req_cap = ompd_pkg::STOP_LEVEL_MAX;
            ompd_pkg::OMPD_STANDBY:
                if (req_level > ompd_pkg::STANDBY_LEVEL_MAX)
                    req_cap = ompd_pkg::STANDBY_LEVEL_MAX;
            default: req_cap = ompd_pkg::RESET_LEVEL;
        endcase
    end

    // qualifying wake event for the current mode
    always_comb begin
        case (mode_q)
            ompd_pkg::OMPD_SLEEP: wake = periph_irq;
            ompd_pkg::OMPD_STOP,
            ompd_pkg::OMPD_STANDBY: wake = periph_irq || low_power_irq;
            ompd_pkg::OMPD_SHUTDOWN:
                wake = external_reset_pin || debug_active
                    || io_wake_match;
            default: wake = 1'b0;
        endcase
    end

    // mode sequencing and clock policy
    always_comb begin
        mode_d = mode_q;
        level_d = level_q;
        run_level_d = run_level_q;
        osc_d = osc_q;
        lpclk_d = lpclk_q;
        reconf_d = 1'b0;
        case (mode_q)
            ompd_pkg::OMPD_RUN: begin
                if (cpu_enter && req_mode != ompd_pkg::OMPD_RUN) begin
                    mode_d = req_mode;
                    level_d = req_cap;
                    run_level_d = level_q;
                end else if (cpu_enter) begin
                    level_d = req_cap;
                end
            end
            ompd_pkg::OMPD_SLEEP,
            ompd_pkg::OMPD_STOP,
            ompd_pkg::OMPD_STANDBY,
            ompd_pkg::OMPD_SHUTDOWN: begin
                if (wake) begin
                    mode_d = ompd_pkg::OMPD_RUN;
                    level_d = run_level_q;
                    reconf_d = (mode_q == ompd_pkg::OMPD_SHUTDOWN);
                end
            end
            default: mode_d = ompd_pkg::OMPD_RUN;
        endcase
        // clock policy for the mode about to be entered
        case (mode_d)
            ompd_pkg::OMPD_RUN,
            ompd_pkg::OMPD_SLEEP: begin
                osc_d = (level_d != ompd_pkg::RUN_LEVEL_TWO);
                lpclk_d = (level_d == ompd_pkg::RESET_LEVEL)
                    ? ompd_pkg::LPCLK_FAST : ompd_pkg::LPCLK_32K;
            end
            ompd_pkg::OMPD_STOP: begin
                if (level_d == ompd_pkg::STOP_LEVEL_ZERO
                    && mode_q == ompd_pkg::OMPD_RUN
                    && level_q != ompd_pkg::RESET_LEVEL) begin
                    // keep oscillator and 32 kHz as in the run level
                    osc_d = (level_q == ompd_pkg::RUN_LEVEL_ONE);
                    lpclk_d = ompd_pkg::LPCLK_32K;
                end else begin
                    osc_d = (level_d <= ompd_pkg::STOP_LEVEL_ONE);
                    lpclk_d = (level_d <= ompd_pkg::STOP_LEVEL_ONE)
                        ? ompd_pkg::LPCLK_4M : ompd_pkg::LPCLK_32K;
                end
            end
            ompd_pkg::OMPD_STANDBY: begin
                osc_d = 1'b0;
                lpclk_d = (level_d == ompd_pkg::STANDBY_LEVEL_ONE)
                    ? ompd_pkg::LPCLK_OFF : ompd_pkg::LPCLK_32K;
            end
            default: begin
                osc_d = 1'b0;
                lpclk_d = ompd_pkg::LPCLK_OFF;
            end
        endcase
        // hold the clocks while mode and level stay put, so stop level zero
        // entered from run level one or two keeps that run level's clocks
        if (mode_d == mode_q && level_d == level_q) begin
            osc_d = osc_q;
            lpclk_d = lpclk_q;
        end
    end

    // state registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= ompd_pkg::OMPD_RUN;
            level_q <= ompd_pkg::RESET_LEVEL;
            run_level_q <= ompd_pkg::RESET_LEVEL;
            osc_q <= 1'b1;
            lpclk_q <= ompd_pkg::LPCLK_FAST;
            reconf_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            level_q <= level_d;
            run_level_q <= run_level_d;
            osc_q <= osc_d;
            lpclk_q <= lpclk_d;
            reconf_q <= reconf_d;
        end
    end

    // domain and core outputs decoded from the mode register
    assign mode = mode_q;
    assign level = level_q;
    assign cpu_run = (mode_q == ompd_pkg::OMPD_RUN);
    assign regulator_on = (mode_q != ompd_pkg::OMPD_SHUTDOWN);
    assign high_perf_domain = (mode_q == ompd_pkg::OMPD_RUN)
        || (mode_q == ompd_pkg::OMPD_SLEEP);
    assign low_power_domain = (mode_q != ompd_pkg::OMPD_SHUTDOWN);
    assign system_oscillator = osc_q;
    assign low_power_periph_clock = lpclk_q;
    assign lp_timer_clk_en = low_power_domain;
    assign periph_fast_req_en = (mode_q == ompd_pkg::OMPD_STANDBY)
        && (level_q == ompd_pkg::STANDBY_LEVEL_ONE);
    assign reconfig_needed = reconf_q;
    assign off_any = !low_power_domain;

    // one gate per governed function
    for (genvar i = 0; i < ompd_pkg::FUNC_N; i++) begin : g_func
        ompd_func_gate u_gate (
            .avail(func_avail[2*i +: 2]),
            .powered_off(off_any),
            .sw_enable(func_sw_enable[i]),
            .clk_en(func_clk_en[i]),
            .pwr_en(func_pwr_en[i])
        );
    end

    // checks
    chk_hp_domain: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (cpu_run && cpu_enter && (req_mode == ompd_pkg::OMPD_STOP
        || req_mode == ompd_pkg::OMPD_STANDBY))
        |=> !high_perf_domain && low_power_domain)
        else $error("high-performance domain wrong for mode");
    chk_lp_domain: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (mode_q == ompd_pkg::OMPD_SHUTDOWN) |-> !low_power_domain
        && !high_perf_domain && !regulator_on)
        else $error("domain powered in shutdown");
    chk_sleep_wake: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (mode_q == ompd_pkg::OMPD_SLEEP && periph_irq)
        |=> mode_q == ompd_pkg::OMPD_RUN)
        else $error("interrupt did not wake");
    chk_shut_hold: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (mode_q == ompd_pkg::OMPD_SHUTDOWN && !external_reset_pin
        && !debug_active && !io_wake_match)
        |=> mode_q == ompd_pkg::OMPD_SHUTDOWN)
        else $error("shutdown left without allowed source");
    chk_cpu_only_run: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (!cpu_run && !periph_irq && !low_power_irq && !external_reset_pin
        && !debug_active && !io_wake_match) |=> !cpu_run)
        else $error("cpu resumed without a wake event");
    chk_enter_mode: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (cpu_run && cpu_enter && req_mode != ompd_pkg::OMPD_RUN)
        |=> mode_q == $past(req_mode))
        else $error("requested mode not entered");
    chk_stop_keep: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (cpu_run && level_q == ompd_pkg::RUN_LEVEL_ONE && cpu_enter
        && req_mode == ompd_pkg::OMPD_STOP
        && req_level == ompd_pkg::STOP_LEVEL_ZERO)
        |=> system_oscillator
        && low_power_periph_clock == ompd_pkg::LPCLK_32K)
        else $error("stop level zero changed clocks");
    chk_stop_hold: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (mode_q == ompd_pkg::OMPD_STOP && !wake)
        |=> $stable(system_oscillator)
        && $stable(low_power_periph_clock))
        else $error("stop clocks changed while held");
    chk_no_enter: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (cpu_run && !cpu_enter) |=> cpu_run)
        else $error("left run without entry signal");
    chk_reconf_pulse: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (mode_q == ompd_pkg::OMPD_SHUTDOWN && external_reset_pin)
        |=> reconfig_needed ##1 !reconfig_needed)
        else $error("reprogram pulse missing");
endmodule
`default_nettype wire

/* core/ompd_func_gate.sv */
// per-function clock and power gate for one operating mode
`timescale 1ns/1ns
`default_nettype none
module ompd_func_gate (
    // class of this function in the current mode
    input wire logic [1:0] avail,
    input wire logic powered_off,
    // software enable of this function
    input wire logic sw_enable,
    // gate outputs
    output logic clk_en,
    output logic pwr_en
);
    // disabled gates the clock only, optional and ns clocks follow software
    always_comb begin
        clk_en = 1'b0;
        pwr_en = !powered_off;
        case (avail)
            ompd_pkg::AVAIL_EN: clk_en = !powered_off;
            ompd_pkg::AVAIL_DIS: clk_en = 1'b0;
            ompd_pkg::AVAIL_OPT: clk_en = sw_enable && !powered_off;
            ompd_pkg::AVAIL_NS: clk_en = sw_enable && !powered_off;
            default: clk_en = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

/* core/ompd_pkg.sv */
// constants and types of the operating mode and power domain controller
package ompd_pkg;
    // power modes, ordered by decreasing consumption
    typedef enum logic [2:0] {
        OMPD_RUN,
        OMPD_SLEEP,
        OMPD_STOP,
        OMPD_STANDBY,
        OMPD_SHUTDOWN
    } ompd_mode_e;
    localparam int unsigned LEVEL_W = 2;
    // highest policy level of each mode
    localparam logic [1:0] RUN_LEVEL_MAX = 2'h2;
    localparam logic [1:0] SLEEP_LEVEL_MAX = 2'h2;
    localparam logic [1:0] STOP_LEVEL_MAX = 2'h2;
    localparam logic [1:0] STANDBY_LEVEL_MAX = 2'h1;
    // named policy levels
    localparam logic [1:0] RUN_LEVEL_ONE = 2'h1;
    localparam logic [1:0] RUN_LEVEL_TWO = 2'h2;
    localparam logic [1:0] STOP_LEVEL_ZERO = 2'h0;
    localparam logic [1:0] STOP_LEVEL_ONE = 2'h1;
    localparam logic [1:0] STANDBY_LEVEL_ONE = 2'h1;
    // number of functions governed per mode
    localparam int unsigned FUNC_N = 8;
    // per-function availability class
    localparam logic [1:0] AVAIL_EN = 2'h0;
    localparam logic [1:0] AVAIL_DIS = 2'h1;
    localparam logic [1:0] AVAIL_OPT = 2'h2;
    localparam logic [1:0] AVAIL_NS = 2'h3;
    // low-power clock rate code: 0 off, 1 32 kHz, 2 4 MHz, 3 fast
    localparam logic [1:0] LPCLK_OFF = 2'h0;
    localparam logic [1:0] LPCLK_32K = 2'h1;
    localparam logic [1:0] LPCLK_4M = 2'h2;
    localparam logic [1:0] LPCLK_FAST = 2'h3;
    // reset values
    localparam logic [1:0] RESET_LEVEL = 2'h0;
endpackage
